//--- rtl/updown_cfg.svh
`ifndef UPDOWN_CFG_SVH
`define UPDOWN_CFG_SVH

// counter width
`define CNT_W 4

// apb byte addresses of the software registers
`define ADDR_CTRL 8'h00
`define ADDR_PRESET 8'h04
`define ADDR_STATUS 8'h08

// control register field positions
`define CTRL_UP_BIT 0
`define CTRL_LOAD_BIT 1
`define CTRL_CLR_BIT 2

// status register field positions (count sits in bits 3:0)
`define STAT_CO_BIT 4
`define STAT_CI_BIT 5

// reset values: count up, no preset, no clear
`define CTRL_RST 3'h1
`define PRESET_RST 4'h0

`endif

//--- rtl/updown_pkg.sv
package updown_pkg;

  // control bits steering the counter core
  typedef struct packed {
    logic clear;
    logic preset_load_enable;
    logic up_down;
  } ctrl_type;

  // register decode result
  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_PRESET = 2'h1,
    SEL_STATUS = 2'h3,
    SEL_NONE = 2'h2
  } reg_sel_type;

  // whole state of the register block
  typedef struct packed {
    ctrl_type ctrl;
    logic [3:0] preset;
    logic [31:0] rdata;
    logic slverr;
  } regs_type;

endpackage

//--- rtl/count_core.sv
`timescale 1ns/10ps
`include "updown_cfg.svh"

module count_core #(
  parameter int WIDTH = `CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire updown_pkg::ctrl_type ctrl,
  input wire logic [WIDTH-1:0] preset_value,
  // cascade
  input wire logic carry_in,
  output logic carry_out,
  // count
  output logic [WIDTH-1:0] count_out
);

  // refuse widths the status word cannot carry
  if (WIDTH < 1 || WIDTH > 4) begin : g_bad_width
    $error("count_core: WIDTH must be 1 to 4");
  end

  // whole state of the core
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } core_state_type;

  core_state_type st_r;
  core_state_type st_nxt;

  // one step either way, wrapping at both ends
  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] v, input logic up);
    step = up ? WIDTH'(v + 1'b1) : WIDTH'(v - 1'b1);
  endfunction

  // next count: clear beats preset beats counting
  always_comb begin
    st_nxt = st_r;
    if (ctrl.clear) begin
      st_nxt.count = '0;
    end else if (ctrl.preset_load_enable) begin
      st_nxt.count = preset_value;
    end else if (!carry_in) begin
      st_nxt.count = step(st_r.count, ctrl.up_down);
    end
  end

  // all bits move together on the rising edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // clear and preset bypass the flops so they show without an edge
  always_comb begin
    if (ctrl.clear) begin
      count_out = '0;
    end else if (ctrl.preset_load_enable) begin
      count_out = preset_value;
    end else begin
      count_out = st_r.count;
    end
  end

  // terminal count flag, active low, for the next stage's carry in
  always_comb begin
    if (ctrl.up_down) begin
      carry_out = !((&count_out) && !carry_in);
    end else begin
      carry_out = !((~|count_out) && !carry_in);
    end
  end

endmodule

//--- rtl/updown_counter_top.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "updown_cfg.svh"

module updown_counter_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cascade with neighbouring stages
  input wire logic carry_in,
  output logic carry_out,
  // count
  output logic [3:0] count_out
);

  // register block state and its next value
  updown_pkg::regs_type st_r;
  updown_pkg::regs_type st_nxt;

  // register map, one aligned 32-bit word each:
  // control: direction, load enable, clear, in that bit order
  // preset: start value in the low bits
  // status: count, carry out, carry in; read only
  // other offsets answer with an error and zero data
  // writes there, and to status, are dropped
  // word address decode, shared by read and write paths
  function automatic updown_pkg::reg_sel_type reg_decode(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    // low two bits ignored: every register is one aligned word
    if (w == `ADDR_CTRL) begin
      reg_decode = updown_pkg::SEL_CTRL;
    end else if (w == `ADDR_PRESET) begin
      reg_decode = updown_pkg::SEL_PRESET;
    end else if (w == `ADDR_STATUS) begin
      reg_decode = updown_pkg::SEL_STATUS;
    end else begin
      reg_decode = updown_pkg::SEL_NONE;
    end
  endfunction

  // apb phase qualifiers
  logic setup_phase;
  logic access_phase;
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // register next-state: read snapshot in setup, write at access edge
  always_comb begin
    st_nxt = st_r;
    // read data is captured in setup so prdata comes from flops
    if (setup_phase) begin
      st_nxt.rdata = 32'h0;
      st_nxt.slverr = 1'b0;
      case (reg_decode(paddr))
        updown_pkg::SEL_CTRL: begin
          st_nxt.rdata[`CTRL_UP_BIT] = st_r.ctrl.up_down;
          st_nxt.rdata[`CTRL_LOAD_BIT] = st_r.ctrl.preset_load_enable;
          st_nxt.rdata[`CTRL_CLR_BIT] = st_r.ctrl.clear;
        end
        updown_pkg::SEL_PRESET: begin
          st_nxt.rdata[3:0] = st_r.preset;
        end
        updown_pkg::SEL_STATUS: begin
          // live counter state as it stands in the setup cycle
          st_nxt.rdata[3:0] = count_out;
          st_nxt.rdata[`STAT_CO_BIT] = carry_out;
          st_nxt.rdata[`STAT_CI_BIT] = carry_in;
        end
        default: begin
          // unmapped: zero data and an error answer
          st_nxt.slverr = 1'b1;
        end
      endcase
    end
    // a write lands only at the completing edge
    if (access_phase && pwrite) begin
      case (reg_decode(paddr))
        updown_pkg::SEL_CTRL: begin
          st_nxt.ctrl.up_down = pwdata[`CTRL_UP_BIT];
          st_nxt.ctrl.preset_load_enable = pwdata[`CTRL_LOAD_BIT];
          st_nxt.ctrl.clear = pwdata[`CTRL_CLR_BIT];
        end
        updown_pkg::SEL_PRESET: begin
          st_nxt.preset = pwdata[3:0];
        end
        default: begin
          // status is read only; writes there are dropped
          st_nxt.preset = st_r.preset;
        end
      endcase
    end
  end

  // register block flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '{ctrl: updown_pkg::ctrl_type'(`CTRL_RST), preset: `PRESET_RST,
                rdata: 32'h0, slverr: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // combinational ready keeps back-to-back transfers free of extra state
  // zero wait state: every access completes in its first access cycle
  assign pready = access_phase;
  // answer comes straight from flops
  assign prdata = st_r.rdata;
  // error flag held from setup through access
  assign pslverr = st_r.slverr;

  // the counter proper; carry in comes from same-clock logic, unsynchronised
  // a synchroniser here would lag the cascade and break wider counts
  count_core #(
    .WIDTH(`CNT_W)
  ) u_core (
    .clock(clock),
    .rst_n(rst_n),
    .ctrl(st_r.ctrl),
    .preset_value(st_r.preset),
    .carry_in(carry_in),
    .carry_out(carry_out),
    .count_out(count_out)
  );

  // checks, all in the main clock domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // shorthand for the control bits in force
  logic clr;
  logic load_on;
  logic up;
  assign clr = st_r.ctrl.clear;
  assign load_on = st_r.ctrl.preset_load_enable;
  assign up = st_r.ctrl.up_down;

  // a counting cycle in either direction
  sequence s_run_up;
    !clr && !load_on && !carry_in && up;
  endsequence

  sequence s_run_down;
    !clr && !load_on && !carry_in && !up;
  endsequence

  // a cycle with no override in force
  sequence s_free;
    !clr && !load_on;
  endsequence

  // the completing edge of a write to one register
  sequence s_wr_ctrl;
    access_phase && pwrite && reg_decode(paddr) == updown_pkg::SEL_CTRL;
  endsequence

  sequence s_wr_preset;
    access_phase && pwrite && reg_decode(paddr) == updown_pkg::SEL_PRESET;
  endsequence

  // a write that must leave every register as it was
  sequence s_wr_dropped;
    access_phase && pwrite && (reg_decode(paddr) == updown_pkg::SEL_STATUS ||
      reg_decode(paddr) == updown_pkg::SEL_NONE);
  endsequence

  // the setup cycle of a read or write of one register
  sequence s_setup_ctrl;
    setup_phase && reg_decode(paddr) == updown_pkg::SEL_CTRL;
  endsequence

  sequence s_setup_preset;
    setup_phase && reg_decode(paddr) == updown_pkg::SEL_PRESET;
  endsequence

  sequence s_setup_status;
    setup_phase && reg_decode(paddr) == updown_pkg::SEL_STATUS;
  endsequence

  // clear wins over everything
  chk_clear_zero: assert property (
    clr |-> (count_out == 4'h0) && !(load_on && count_out != 4'h0))
    else $error("count not zero under clear");

  // preset shows in the same cycle, no edge needed
  chk_preset_now: assert property (
    (!clr && load_on) |-> count_out == st_r.preset)
    else $error("preset value not on count");

  // preset stays the base once load enable drops
  chk_preset_keep: assert property (
    (!clr && load_on) ##1 (s_free and carry_in) |-> count_out == $past(st_r.preset))
    else $error("preset value lost after load");

  // up count steps by one
  chk_count_up: assert property (
    s_run_up ##1 s_free |-> count_out == 4'($past(count_out) + 4'h1))
    else $error("up count step wrong");

  // down count steps by one
  chk_count_down: assert property (
    s_run_down ##1 s_free |-> count_out == 4'($past(count_out) - 4'h1))
    else $error("down count step wrong");

  // carry in high holds the count
  chk_hold_carry: assert property (
    (s_free and carry_in) ##1 s_free |-> $stable(count_out))
    else $error("count moved with carry in high");

  // wrap at both ends
  chk_wrap_ends: assert property (
    ((s_run_up and count_out == 4'hF) or (s_run_down and count_out == 4'h0))
    ##1 s_free |-> count_out == ($past(up) ? 4'h0 : 4'hF))
    else $error("count did not wrap");

  // carry out in up direction
  chk_co_up: assert property (
    up |-> carry_out == !(count_out == 4'hF && !carry_in))
    else $error("carry out wrong counting up");

  // carry out in down direction
  chk_co_down: assert property (
    !up |-> carry_out == !(count_out == 4'h0 && !carry_in))
    else $error("carry out wrong counting down");

  // a control write steers the core on the next cycle
  chk_ctrl_write: assert property (
    s_wr_ctrl |=> st_r.ctrl == updown_pkg::ctrl_type'($past(pwdata[2:0])))
    else $error("control write not applied");

  // a preset write lands at its completing edge
  chk_preset_write: assert property (
    s_wr_preset |=> st_r.preset == $past(pwdata[3:0]))
    else $error("preset write not applied");

  // status and unmapped writes change nothing
  chk_write_dropped: assert property (
    s_wr_dropped |=> $stable(st_r.preset) && $stable(st_r.ctrl))
    else $error("dropped write changed a register");

  // control read shows the bits in force at setup
  chk_ctrl_read: assert property (
    s_setup_ctrl |=> prdata == {29'h0, $past(st_r.ctrl)})
    else $error("control read data wrong");

  // preset read shows the stored start value
  chk_preset_read: assert property (
    s_setup_preset |=> prdata == {28'h0, $past(st_r.preset)})
    else $error("preset read data wrong");

  // status read is the live state of the setup cycle
  chk_status_snap: assert property (
    s_setup_status |=> prdata[3:0] == $past(count_out) &&
      prdata[`STAT_CO_BIT] == $past(carry_out) && prdata[`STAT_CI_BIT] == $past(carry_in))
    else $error("status snapshot wrong");

  // unmapped read answers with an error
  chk_bad_addr: assert property (
    (access_phase && reg_decode(paddr) == updown_pkg::SEL_NONE)
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  // mapped accesses answer without error
  chk_good_addr: assert property (
    setup_phase && reg_decode(paddr) != updown_pkg::SEL_NONE |=> !pslverr)
    else $error("mapped access refused");

  // every access completes in its first access cycle
  chk_zero_wait: assert property (
    access_phase |-> pready)
    else $error("access cycle not answered");

  // no answer without a select
  chk_idle_ready: assert property (
    !psel |-> !pready)
    else $error("ready raised while idle");

  // a high carry in keeps carry out high in both directions
  chk_carry_idle: assert property (
    carry_in |-> carry_out)
    else $error("carry out low with carry in high");

endmodule

//--- dv/cascade_stage_model.sv
`timescale 1ns/10ps
module cascade_stage_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cascade
  input wire logic carry_in,
  output logic carry_out
);
  // lower stage count, up only
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  // steps only while its own carry in is low
  always_comb begin
    count_nxt = count_r;
    if (!carry_in) begin
      count_nxt = count_r + 4'h1;
    end
  end
  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= 4'h0;
    end else begin
      count_r <= count_nxt;
    end
  end
  // terminal count feeds the next stage, so it steps once in sixteen
  assign carry_out = ~((count_r == 4'hF) && !carry_in);
endmodule

//--- dv/test_up_down_binary_counter_4bit.sv
`timescale 1ns/10ps
module test_up_down_binary_counter_4bit;
  // bench signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stage_en_n = 1'b1; // lower stage stopped
  logic carry_in;
  logic carry_out;
  logic [3:0] count_out;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  always #5 clock = ~clock;

  // lower neighbour drives our carry in
  cascade_stage_model low_u (.clock(clock), .rst_n(rst_n), .carry_in(stage_en_n),
    .carry_out(carry_in));

  updown_counter_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .carry_in(carry_in), .carry_out(carry_out), .count_out(count_out));

  // compare and report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // the wait ends at the first edge with pready high, or at the hang guard
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one counting step: hold while carry in high, then step
  task automatic step(input logic [3:0] exp_cnt, input logic exp_co);
    logic [3:0] held;
    @(negedge clock);
    held = count_out;
    while (carry_in !== 1'b0) begin
      chk("hold count", count_out, held);
      chk("carry out idle", carry_out, 1'b1);
      @(negedge clock);
    end
    chk("carry out", carry_out, exp_co);
    @(negedge clock);
    chk("count", count_out, exp_cnt);
  endtask

  // reset values and unmapped access
  task automatic reset_and_map;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("preset reset", rd, 32'h0);
    chk("count reset", count_out, 4'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    @(negedge clock);
    chk("idle ready", pready, 1'b0);
  endtask

  // preset beats counting, clear beats preset
  task automatic preset_and_clear;
    apb(1'b1, 8'h04, 32'hA);
    apb(1'b1, 8'h00, 32'h3);
    stage_en_n <= 1'b0;
    @(negedge clock);
    chk("preset load", count_out, 4'hA);
    repeat (20) @(negedge clock);
    chk("preset holds", count_out, 4'hA);
    apb(1'b1, 8'h00, 32'h7);
    @(negedge clock);
    chk("clear wins", count_out, 4'h0);
    @(posedge clock);
    stage_en_n <= 1'b1;
  endtask

  // count in one direction from a preset start
  task automatic run(input logic up, input logic [3:0] start, input logic [3:0] b, c);
    apb(1'b1, 8'h04, {28'h0, start});
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h00, {31'h0, up});
    stage_en_n <= 1'b0;
    step(b, 1'b1);
    step(c, 1'b0);
    @(posedge clock);
    stage_en_n <= 1'b1;
    repeat (2) @(posedge clock);
    apb(1'b1, 8'h08, 32'hF);
    apb(1'b0, 8'h08, 32'h0);
    chk("status", rd, {26'h0, 2'h3, c});
    chk("status err", err, 1'b0);
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    reset_and_map;
    preset_and_clear;
    run(1'b1, 4'hE, 4'hF, 4'h0);
    run(1'b0, 4'h1, 4'h0, 4'hF);
    tally_and_finish;
  end
endmodule
